// file: rxmc_ctrl_reg.sv
`timescale 1ns/1ps
module rxmc_ctrl_reg (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [rxmc_pkg::CTRL_W-1:0] wdata,
    output logic [rxmc_pkg::CTRL_W-1:0] ctrl_q
);
    logic [rxmc_pkg::CTRL_W-1:0] ctrl_d;

    // only the three writable bits are stored; reserved bits have no flops
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_en) begin
            ctrl_d = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_q <= rxmc_pkg::CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
endmodule : rxmc_ctrl_reg

// file: rxmc_irq_pin.sv
`timescale 1ns/1ps
module rxmc_irq_pin (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pending,
    input wire logic active_high,
    output logic pin_out_q,
    output logic pin_oe_n_q
);
    logic pin_out_d;
    logic pin_oe_n_d;

    always_comb begin
        if (active_high) begin
            pin_out_d = pending;
            pin_oe_n_d = 1'b0;
        end else begin
            // open-drain style so several sources share one wire
            pin_out_d = 1'b0;
            pin_oe_n_d = !pending;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_out_q <= 1'b0;
            pin_oe_n_q <= 1'b1;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end
endmodule : rxmc_irq_pin

// file: rxmc_pkg.sv
package rxmc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] ADDR_RX_CODE_HIGH = 8'h63;
    localparam logic [7:0] ADDR_ROM_FW_VER = 8'h70;
    localparam logic [7:0] ADDR_RAM_FW_MAJOR = 8'h71;
    localparam logic [7:0] ADDR_RAM_FW_MINOR = 8'h72;
    localparam logic [7:0] ADDR_CHIP_IDENT_LO = 8'h80;
    localparam logic [7:0] ADDR_CHIP_IDENT_HI = 8'h81;
    localparam logic [7:0] ADDR_MISC_CONTROL = 8'hee;

    // field layout
    localparam int RX_CODE_HI_W = 2;
    localparam int CTRL_W = 3;
    localparam int BIT_MICRO_SOFT_RESET = 0;
    localparam int BIT_CODE_MEMORY_SEL = 1;
    localparam int BIT_IRQ_POLARITY_SEL = 2;

    // reset values
    localparam logic [1:0] RX_CODE_HI_RST = 2'h0;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [7:0] RDATA_RST = 8'h00;
endpackage : rxmc_pkg

// file: rxmc_regs.sv
// Summary of operation
// - upper receive register shows code word bits 9:8 in bits 1:0, rest zero
// - read-only byte reports the ROM firmware version
// - read-only byte reports the RAM firmware major version
// - read-only byte reports the RAM firmware minor version
// - sixteen-bit identity code: low byte at lower address, high byte next
// - polarity bit 2: clear gives active-low request, set gives active-high
// - active-low mode releases the request pin when inactive
// - bit 1 selects micro code memory: clear ROM, set RAM
// - bit 0 holds the micro in reset while set
// - control bits 7:3 read zero; bits 2:0 read/write, reset zero
// - request pin asserts when any unmasked status bit is set
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module rxmc_regs #(
    parameter logic [7:0] ROM_FW_VERSION = 8'h5a, // arbitrary value
    parameter logic [15:0] CHIP_IDENT = 16'ha5c3, // arbitrary value
    parameter int IRQ_SRC_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [rxmc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rxmc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rxmc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic rx_code_load,
    input wire logic [rxmc_pkg::RX_CODE_HI_W-1:0] rx_code_hi,
    input wire logic [7:0] ram_fw_major,
    input wire logic [7:0] ram_fw_minor,
    input wire logic [IRQ_SRC_W-1:0] irq_status_vec,
    output logic host_irq_out,
    output logic host_irq_oe_n,
    output logic code_memory_sel,
    output logic micro_soft_reset
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic [rxmc_pkg::RX_CODE_HI_W-1:0] rx_code_q;
    logic [rxmc_pkg::RX_CODE_HI_W-1:0] rx_code_d;
    logic [rxmc_pkg::DATA_W-1:0] rdata_q;
    logic [rxmc_pkg::DATA_W-1:0] rdata_d;
    logic [rxmc_pkg::CTRL_W-1:0] ctrl_q;
    logic ctrl_wr;
    logic pending_any;
    logic irq_pol;

    ////////////////////////////////////////////////////////////////////////
    // upper receive code bits
    always_comb begin
        rx_code_d = rx_code_q;
        if (rx_code_load) begin
            // antenna logic wins over a host write in the same cycle
            rx_code_d = rx_code_hi;
        end else if (reg_wr && hit(reg_addr, rxmc_pkg::ADDR_RX_CODE_HIGH)) begin
            rx_code_d = reg_wdata[rxmc_pkg::RX_CODE_HI_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_code_q <= rxmc_pkg::RX_CODE_HI_RST;
        end else begin
            rx_code_q <= rx_code_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register and its outputs
    assign ctrl_wr = reg_wr && hit(reg_addr, rxmc_pkg::ADDR_MISC_CONTROL);

    rxmc_ctrl_reg u_ctrl (
        .clk(clk),
        .rstn(rstn),
        .wr_en(ctrl_wr),
        .wdata(reg_wdata[rxmc_pkg::CTRL_W-1:0]),
        .ctrl_q(ctrl_q)
    );

    assign code_memory_sel = ctrl_q[rxmc_pkg::BIT_CODE_MEMORY_SEL];
    assign micro_soft_reset = ctrl_q[rxmc_pkg::BIT_MICRO_SOFT_RESET];
    assign irq_pol = ctrl_q[rxmc_pkg::BIT_IRQ_POLARITY_SEL];

    ////////////////////////////////////////////////////////////////////////
    // interrupt request pin
    // status bits arrive already masked; this block only merges them
    assign pending_any = |irq_status_vec;

    rxmc_irq_pin u_irq (
        .clk(clk),
        .rstn(rstn),
        .pending(pending_any),
        .active_high(irq_pol),
        .pin_out_q(host_irq_out),
        .pin_oe_n_q(host_irq_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // read path: data valid only in the cycle after the strobe
    always_comb begin
        rdata_d = rxmc_pkg::RDATA_RST;
        if (reg_rd) begin
            if (hit(reg_addr, rxmc_pkg::ADDR_RX_CODE_HIGH)) begin
                rdata_d = {6'h00, rx_code_q};
            end else if (hit(reg_addr, rxmc_pkg::ADDR_ROM_FW_VER)) begin
                rdata_d = ROM_FW_VERSION;
            end else if (hit(reg_addr, rxmc_pkg::ADDR_RAM_FW_MAJOR)) begin
                rdata_d = ram_fw_major;
            end else if (hit(reg_addr, rxmc_pkg::ADDR_RAM_FW_MINOR)) begin
                rdata_d = ram_fw_minor;
            end else if (hit(reg_addr, rxmc_pkg::ADDR_CHIP_IDENT_LO)) begin
                rdata_d = CHIP_IDENT[7:0];
            end else if (hit(reg_addr, rxmc_pkg::ADDR_CHIP_IDENT_HI)) begin
                rdata_d = CHIP_IDENT[15:8];
            end else if (hit(reg_addr, rxmc_pkg::ADDR_MISC_CONTROL)) begin
                rdata_d = {5'h00, ctrl_q};
            end else begin
                // unmapped addresses read zero
                rdata_d = rxmc_pkg::RDATA_RST;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_q <= rxmc_pkg::RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic wbit_code;
    logic wbit_rst;
    assign wbit_code = reg_wdata[rxmc_pkg::BIT_CODE_MEMORY_SEL];
    assign wbit_rst = reg_wdata[rxmc_pkg::BIT_MICRO_SOFT_RESET];

    logic wbit_pol;
    assign wbit_pol = reg_wdata[rxmc_pkg::BIT_IRQ_POLARITY_SEL];

    // every mapped offset; anything else has to read back as zero
    logic rd_mapped;
    assign rd_mapped = hit(reg_addr, rxmc_pkg::ADDR_RX_CODE_HIGH)
        || hit(reg_addr, rxmc_pkg::ADDR_ROM_FW_VER)
        || hit(reg_addr, rxmc_pkg::ADDR_RAM_FW_MAJOR)
        || hit(reg_addr, rxmc_pkg::ADDR_RAM_FW_MINOR)
        || hit(reg_addr, rxmc_pkg::ADDR_CHIP_IDENT_LO)
        || hit(reg_addr, rxmc_pkg::ADDR_CHIP_IDENT_HI)
        || hit(reg_addr, rxmc_pkg::ADDR_MISC_CONTROL);

    a_rx_code_read: assert property (
        reg_rd && hit(reg_addr, rxmc_pkg::ADDR_RX_CODE_HIGH)
        |=> reg_rdata == {6'h00, $past(rx_code_q)})
        else $error("upper receive code read mismatch");

    a_rx_code_load: assert property (
        rx_code_load |=> rx_code_q == $past(rx_code_hi))
        else $error("receive code not captured");

    a_rom_ver_read: assert property (
        reg_rd && hit(reg_addr, rxmc_pkg::ADDR_ROM_FW_VER)
        |=> reg_rdata == ROM_FW_VERSION)
        else $error("rom version read mismatch");

    a_ram_major_read: assert property (
        reg_rd && hit(reg_addr, rxmc_pkg::ADDR_RAM_FW_MAJOR)
        |=> reg_rdata == $past(ram_fw_major))
        else $error("ram major version read mismatch");

    a_ram_minor_read: assert property (
        reg_rd && hit(reg_addr, rxmc_pkg::ADDR_RAM_FW_MINOR)
        |=> reg_rdata == $past(ram_fw_minor))
        else $error("ram minor version read mismatch");

    a_ident_lo_read: assert property (
        reg_rd && hit(reg_addr, rxmc_pkg::ADDR_CHIP_IDENT_LO)
        |=> reg_rdata == CHIP_IDENT[7:0])
        else $error("identity low byte mismatch");

    a_ident_hi_read: assert property (
        reg_rd && hit(reg_addr, rxmc_pkg::ADDR_CHIP_IDENT_HI)
        |=> reg_rdata == CHIP_IDENT[15:8])
        else $error("identity high byte mismatch");

    a_irq_high_drive: assert property (
        irq_pol && pending_any |=> host_irq_out && !host_irq_oe_n)
        else $error("active-high request not driven");

    a_irq_low_drive: assert property (
        !irq_pol && pending_any |=> !host_irq_out && !host_irq_oe_n)
        else $error("active-low request not driven low");

    a_irq_low_release: assert property (
        !irq_pol && !pending_any |=> host_irq_oe_n)
        else $error("inactive active-low request not released");

    a_irq_or_idle: assert property (
        irq_pol && !pending_any |=> !host_irq_out && !host_irq_oe_n)
        else $error("active-high request asserted without status");

    a_code_mem_write: assert property (
        ctrl_wr |=> code_memory_sel == $past(wbit_code))
        else $error("code memory select not written");

    a_soft_reset_hold: assert property (
        micro_soft_reset && !ctrl_wr |=> micro_soft_reset)
        else $error("micro reset dropped without a write");

    a_soft_reset_write: assert property (
        ctrl_wr |=> micro_soft_reset == $past(wbit_rst))
        else $error("micro reset bit not written");

    a_misc_readback: assert property (
        reg_rd && hit(reg_addr, rxmc_pkg::ADDR_MISC_CONTROL)
        |=> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] == $past(ctrl_q))
        else $error("control readback mismatch");

    a_ro_write_ignored: assert property (
        reg_wr && !ctrl_wr |=> $stable(ctrl_q))
        else $error("control changed by foreign write");

    a_rdata_idle_zero: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");

    a_rx_code_reserved: assert property (
        reg_rd && hit(reg_addr, rxmc_pkg::ADDR_RX_CODE_HIGH)
        |=> reg_rdata[7:2] == 6'h00)
        else $error("upper receive reserved bits not zero");

    a_rx_host_write: assert property (
        reg_wr && hit(reg_addr, rxmc_pkg::ADDR_RX_CODE_HIGH) && !rx_code_load
        |=> rx_code_q == $past(reg_wdata[rxmc_pkg::RX_CODE_HI_W-1:0]))
        else $error("host write of receive code bits lost");

    a_rx_code_hold: assert property (
        !rx_code_load && !(reg_wr && hit(reg_addr, rxmc_pkg::ADDR_RX_CODE_HIGH))
        |=> $stable(rx_code_q))
        else $error("receive code changed without load or write");

    a_rx_load_priority: assert property (
        rx_code_load && reg_wr && hit(reg_addr, rxmc_pkg::ADDR_RX_CODE_HIGH)
        |=> rx_code_q == $past(rx_code_hi))
        else $error("host write beat antenna capture");

    a_irq_pol_write: assert property (
        ctrl_wr |=> irq_pol == $past(wbit_pol))
        else $error("polarity bit not written");

    a_irq_pol_hold: assert property (
        !ctrl_wr |=> $stable(irq_pol))
        else $error("polarity changed without a write");

    a_code_mem_hold: assert property (
        !ctrl_wr |=> $stable(code_memory_sel))
        else $error("code memory select changed without a write");

    a_soft_reset_idle: assert property (
        !micro_soft_reset && !ctrl_wr |=> !micro_soft_reset)
        else $error("micro reset raised without a write");

    a_unmapped_read_zero: assert property (
        reg_rd && !rd_mapped |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");

    a_irq_low_quiet: assert property (
        !irq_pol |=> !host_irq_out)
        else $error("active-low request drove a high level");

    a_irq_high_enable: assert property (
        irq_pol |=> !host_irq_oe_n)
        else $error("active-high request pin not driven");

    a_irq_pending_drive: assert property (
        pending_any
        |=> !host_irq_oe_n && host_irq_out == $past(irq_pol))
        else $error("pending status not shown on request pin");

    c_irq_high_fire: cover property (
        irq_pol && pending_any ##1 host_irq_out);

    c_micro_reset_cycle: cover property (
        micro_soft_reset ##[1:20] !micro_soft_reset);

    c_ident_pair_read: cover property (
        reg_rd && hit(reg_addr, rxmc_pkg::ADDR_CHIP_IDENT_LO)
        ##1 reg_rd && hit(reg_addr, rxmc_pkg::ADDR_CHIP_IDENT_HI));

    c_irq_low_release: cover property (
        !irq_pol && pending_any ##1 !pending_any ##1 host_irq_oe_n);

    c_rx_load_collide: cover property (
        rx_code_load && reg_wr && hit(reg_addr, rxmc_pkg::ADDR_RX_CODE_HIGH));

endmodule : rxmc_regs

// file: rxmc_regs_tb.sv
`timescale 1ns/1ps
module rxmc_regs_tb;
    localparam logic [7:0] ROM_V = 8'h3c; // arbitrary value
    localparam logic [15:0] IDENT = 16'h6b17; // arbitrary value
    logic clk;
    logic rstn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic rx_code_load;
    logic [1:0] rx_code_hi;
    logic [7:0] ram_fw_major;
    logic [7:0] ram_fw_minor;
    logic [7:0] irq_status_vec;
    logic host_irq_out;
    logic host_irq_oe_n;
    logic code_memory_sel;
    logic micro_soft_reset;
    int num_errors;
    int num_checks;

    rxmc_regs #(.ROM_FW_VERSION(ROM_V), .CHIP_IDENT(IDENT), .IRQ_SRC_W(8)) u_dut (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_code_load(rx_code_load), .rx_code_hi(rx_code_hi),
        .ram_fw_major(ram_fw_major), .ram_fw_minor(ram_fw_minor),
        .irq_status_vec(irq_status_vec), .host_irq_out(host_irq_out),
        .host_irq_oe_n(host_irq_oe_n), .code_memory_sel(code_memory_sel),
        .micro_soft_reset(micro_soft_reset)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(name, reg_rdata, exp);
    endtask : rd_chk

    task automatic pins_chk(input logic [7:0] st, input logic oe_n, input logic out);
        @(posedge clk);
        irq_status_vec <= st;
        @(posedge clk);
        #1;
        check("irq_oe_n", {7'h0, host_irq_oe_n}, {7'h0, oe_n});
        check("irq_out", {7'h0, host_irq_out}, {7'h0, out});
    endtask : pins_chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////////
    // about 120 cycles are expected; this is generous
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        num_errors = 0;
        num_checks = 0;
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rx_code_load = 1'b0;
        rx_code_hi = 2'h0;
        ram_fw_major = 8'h12;
        ram_fw_minor = 8'h34;
        irq_status_vec = 8'h00;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        #1;
        check("ctrl_outs", {6'h0, code_memory_sel, micro_soft_reset}, 8'h00);
        check("irq_oe_n", {7'h0, host_irq_oe_n}, 8'h01);
        rd_chk("rx_code_high", 8'h63, 8'h00);
        rd_chk("misc_control", 8'hee, 8'h00);
        rd_chk("rom_fw", 8'h70, ROM_V);
        rd_chk("ram_major", 8'h71, 8'h12);
        rd_chk("ram_minor", 8'h72, 8'h34);
        rd_chk("ident_lo", 8'h80, IDENT[7:0]);
        rd_chk("ident_hi", 8'h81, IDENT[15:8]);
        @(posedge clk);
        ram_fw_major <= 8'ha7;
        rd_chk("ram_major_live", 8'h71, 8'ha7);
        $display("test reset_and_ids done");

        // read-only places, then an unmapped one
        wr(8'h70, 8'hff);
        wr(8'h80, 8'hff);
        wr(8'h81, 8'h00);
        wr(8'h10, 8'hff);
        rd_chk("rom_fw_kept", 8'h70, ROM_V);
        rd_chk("ident_lo_kept", 8'h80, IDENT[7:0]);
        rd_chk("ident_hi_kept", 8'h81, IDENT[15:8]);
        rd_chk("unmapped", 8'h10, 8'h00);
        wr(8'hee, 8'hfb);
        #1;
        check("ctrl_outs", {6'h0, code_memory_sel, micro_soft_reset}, 8'h03);
        rd_chk("misc_control", 8'hee, 8'h03);
        wr(8'hee, 8'hfd);
        rd_chk("misc_control", 8'hee, 8'h05);
        check("ctrl_outs", {6'h0, code_memory_sel, micro_soft_reset}, 8'h01);
        $display("test control_bits done");

        // antenna capture and a host write in the same cycle: capture wins
        wr(8'h63, 8'hfe);
        rd_chk("rx_code_high", 8'h63, 8'h02);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= 8'h63;
        reg_wdata <= 8'h03;
        rx_code_load <= 1'b1;
        rx_code_hi <= 2'h1;
        @(posedge clk);
        reg_wr <= 1'b0;
        rx_code_load <= 1'b0;
        rd_chk("rx_code_high", 8'h63, 8'h01);
        $display("test rx_code done");

        // active low: released when idle, driven low while pending; active high: always driven, high while pending
        wr(8'hee, 8'h00);
        for (int i = 0; i < 8; i++) begin
            pins_chk(8'h01 << i, 1'b0, 1'b0);
            pins_chk(8'h00, 1'b1, 1'b0);
        end
        wr(8'hee, 8'h04);
        pins_chk(8'h00, 1'b0, 1'b0);
        pins_chk(8'h81, 1'b0, 1'b1);
        pins_chk(8'h00, 1'b0, 1'b0);
        $display("test irq_pin done");

        // second reset in mid-run
        wr(8'hee, 8'h07);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        check("ctrl_outs", {6'h0, code_memory_sel, micro_soft_reset}, 8'h00);
        check("irq_oe_n", {7'h0, host_irq_oe_n}, 8'h01);
        rd_chk("misc_control", 8'hee, 8'h00);
        rd_chk("rx_code_high", 8'h63, 8'h00);
        $display("test mid_reset done");
        report_and_stop();
    end
endmodule : rxmc_regs_tb
